// ---- shared/bcdcu_pkg.sv ----
// Package for the BCD correction unit: register map, field layout, command codes, constants
`default_nettype none
package bcdcu_pkg;
    // Byte offsets on the AXI4-Lite slave (12-bit address window)
    localparam logic [11:0] ADDR_ACC      = 12'h000;
    localparam logic [11:0] ADDR_FLAGS    = 12'h004;
    localparam logic [11:0] ADDR_OPERAND  = 12'h008;
    localparam logic [11:0] ADDR_COMMAND  = 12'h00C;
    localparam logic [11:0] ADDR_ADJUST   = 12'h0FC;
    localparam logic [19:0] ADJUST_CPU_ADDR = 20'hF00FE;
    // Flag register fields
    localparam int FLAG_CARRY_BIT = 0;
    localparam int FLAG_HALF_BIT  = 1;
    // Command register codes
    localparam logic [1:0] CMD_ADD     = 2'h1;
    localparam logic [1:0] CMD_SUB     = 2'h2;
    localparam logic [1:0] CMD_ADD_ADJ = 2'h3;
    localparam logic [1:0] CMD_NONE    = 2'h0;
    // Reset values
    localparam logic [7:0] ACC_RESET   = 8'h00;
    localparam logic [1:0] FLAGS_RESET = 2'h0;
    // Digit correction constants
    localparam logic [3:0] DIGIT_MAX   = 4'h9;
    localparam logic [3:0] DIGIT_FIX   = 4'h6;
    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// ---- rtl/bcdcu_adjust.sv ----
// Combinational decimal correction value from accumulator and flags
`default_nettype none
module bcdcu_adjust
(
    // Accumulator state
    input  wire logic [7:0] acc,
    input  wire logic       carry,
    input  wire logic       half,
    // Correction value
    output logic      [7:0] adjust
);
    always_comb
    begin
        adjust = 8'h00;
        // Low digit: half carry or digit above nine [RULE15] [RULE4]
        if (half || (acc[3:0] > bcdcu_pkg::DIGIT_MAX))
        begin
            adjust[3:0] = bcdcu_pkg::DIGIT_FIX;
        end
        // High digit: carry or byte above 99H, so a 9 rolled over by the low fix is caught
        // [RULE15] [RULE4] [RULE8]
        if (carry || (acc > {bcdcu_pkg::DIGIT_MAX, bcdcu_pkg::DIGIT_MAX}))
        begin
            adjust[7:4] = bcdcu_pkg::DIGIT_FIX;
        end
    end
endmodule
`default_nettype wire

// ---- rtl/bcdcu_top.sv ----
// BCD correction unit with accumulator ALU behind an AXI4-Lite slave
// Operation
// RULE1: Software loads the augend into the accumulator before the binary add.
// RULE2: Binary add writes the sum to accumulator; correction value follows.
// RULE3: Adding the correction gives the packed BCD sum, decimal carry in carry.
// RULE4: Correction read is derived from accumulator and flags at read time.
// RULE5: Software issues the correcting operation as the very next instruction.
// RULE6: Interrupt handlers save accumulator; flags restored by status word reload.
// RULE7: 99H plus 89H gives 22H, correction 66H, then 88H carry set.
// RULE8: 85H plus 15H gives 9AH, correction 66H, then 00H both flags set.
// RULE9: 80H plus 80H gives 00H carry, correction 60H, then 60H carry.
// RULE10: Binary subtract writes difference to accumulator; correction value follows.
// RULE11: Subtracting the correction gives packed BCD difference, borrow in carry.
// RULE12: 91H minus 52H gives 3FH half set, correction 06H, then 39H.
// RULE13: Correction location is eight bit, read only, undefined after reset.
// RULE14: Software reads the correction only with byte accesses.
// RULE15: Low fix 6 on half carry or digit over 9; high on carry or over 99H.
`default_nettype none
module bcdcu_top
(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    // AXI4-Lite write address
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    ////////////////////////////////////////////////////////////////////////////
    // Accumulator state and correction value
    logic [7:0] acc_reg;
    logic [7:0] acc_next;
    logic       carry_reg;
    logic       carry_next;
    logic       half_reg;
    logic       half_next;
    logic [7:0] operand_reg;
    logic [7:0] operand_next;
    logic [7:0] adjust_value;

    bcdcu_adjust u_adjust
    (
        .acc    (acc_reg),
        .carry  (carry_reg),
        .half   (half_reg),
        .adjust (adjust_value)
    );

    // Binary add or subtract of the accumulator with a byte, returning flags
    function automatic logic [9:0] alu_op(input logic [7:0] a, input logic [7:0] b,
                                          input logic sub);
        logic [8:0] full;
        logic [4:0] low;
        full = 9'h000;
        low  = 5'h00;
        if (sub)
        begin
            full = {1'b0, a} - {1'b0, b};
            low  = {1'b0, a[3:0]} - {1'b0, b[3:0]};
        end
        else
        begin
            full = {1'b0, a} + {1'b0, b};
            low  = {1'b0, a[3:0]} + {1'b0, b[3:0]};
        end
        // {carry or borrow, half carry or borrow, result}
        return {full[8], low[4], full[7:0]};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave: both write channels taken together, one write answer outstanding at a time
    logic        awready_reg;
    logic        awready_next;
    logic        wready_reg;
    logic        wready_next;
    logic        bvalid_reg;
    logic        bvalid_next;
    logic [1:0]  bresp_reg;
    logic [1:0]  bresp_next;
    logic        arready_reg;
    logic        arready_next;
    logic        rvalid_reg;
    logic        rvalid_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic [1:0]  rresp_reg;
    logic [1:0]  rresp_next;
    logic        wr_fire;
    logic        rd_fire;
    logic [9:0]  alu_res;

    // Write is taken only when address and data are both present
    assign wr_fire = s_axi_awvalid && s_axi_wvalid && !bvalid_reg
                     && !awready_reg && !wready_reg;
    assign rd_fire = s_axi_arvalid && !rvalid_reg && !arready_reg;

    always_comb
    begin
        acc_next     = acc_reg;
        carry_next   = carry_reg;
        half_next    = half_reg;
        operand_next = operand_reg;
        awready_next = 1'b0;
        wready_next  = 1'b0;
        bvalid_next  = bvalid_reg && !s_axi_bready;
        bresp_next   = bresp_reg;
        alu_res      = 10'h000;
        if (wr_fire)
        begin
            awready_next = 1'b1;
            wready_next  = 1'b1;
            bvalid_next  = 1'b1;
            bresp_next   = bcdcu_pkg::RESP_OKAY;
            unique case (s_axi_awaddr)
                bcdcu_pkg::ADDR_ACC:
                begin
                    // Augend loaded by software before the add
                    if (s_axi_wstrb[0])
                    begin
                        acc_next = s_axi_wdata[7:0];
                    end
                end
                bcdcu_pkg::ADDR_FLAGS:
                begin
                    // Flag reload, as a status word restore does
                    if (s_axi_wstrb[0])
                    begin
                        carry_next = s_axi_wdata[bcdcu_pkg::FLAG_CARRY_BIT];
                        half_next  = s_axi_wdata[bcdcu_pkg::FLAG_HALF_BIT];
                    end
                end
                bcdcu_pkg::ADDR_OPERAND:
                begin
                    if (s_axi_wstrb[0])
                    begin
                        operand_next = s_axi_wdata[7:0];
                    end
                end
                bcdcu_pkg::ADDR_COMMAND:
                begin
                    if (s_axi_wstrb[0])
                    begin
                        unique case (s_axi_wdata[1:0])
                            bcdcu_pkg::CMD_ADD:
                            begin
                                // Binary sum and flags stored [RULE2] [RULE7] [RULE8] [RULE9]
                                alu_res = alu_op(acc_reg, operand_reg, 1'b0);
                            end
                            bcdcu_pkg::CMD_SUB:
                            begin
                                // Binary difference and borrows stored [RULE10] [RULE12]
                                alu_res = alu_op(acc_reg, operand_reg, 1'b1);
                            end
                            bcdcu_pkg::CMD_ADD_ADJ:
                            begin
                                // Correcting add yields packed BCD sum [RULE3]
                                alu_res = alu_op(acc_reg, adjust_value, 1'b0);
                                // The decimal carry may come from the binary add alone [RULE7]
                                alu_res[9] = alu_res[9] | carry_reg;
                            end
                            bcdcu_pkg::CMD_NONE:
                            begin
                                // Correcting subtract yields BCD difference [RULE11]
                                alu_res = alu_op(acc_reg, adjust_value, 1'b1);
                                // A borrow of the binary subtract must outlive the fix [RULE11]
                                alu_res[9] = alu_res[9] | carry_reg;
                            end
                        endcase
                        acc_next   = alu_res[7:0];
                        half_next  = alu_res[8];
                        carry_next = alu_res[9];
                    end
                end
                default:
                begin
                    // Correction location is read only [RULE13]
                    bresp_next = bcdcu_pkg::RESP_SLVERR;
                end
            endcase
        end
    end

    always_comb
    begin
        arready_next = 1'b0;
        rvalid_next  = rvalid_reg && !s_axi_rready;
        rdata_next   = rdata_reg;
        rresp_next   = rresp_reg;
        if (rd_fire)
        begin
            arready_next = 1'b1;
            rvalid_next  = 1'b1;
            rresp_next   = bcdcu_pkg::RESP_OKAY;
            rdata_next   = 32'h0000_0000;
            unique case (s_axi_araddr)
                bcdcu_pkg::ADDR_ACC:
                begin
                    rdata_next[7:0] = acc_reg;
                end
                bcdcu_pkg::ADDR_FLAGS:
                begin
                    rdata_next[bcdcu_pkg::FLAG_CARRY_BIT] = carry_reg;
                    rdata_next[bcdcu_pkg::FLAG_HALF_BIT]  = half_reg;
                end
                bcdcu_pkg::ADDR_OPERAND:
                begin
                    rdata_next[7:0] = operand_reg;
                end
                bcdcu_pkg::ADDR_COMMAND:
                begin
                    rdata_next = 32'h0000_0000;
                end
                bcdcu_pkg::ADDR_ADJUST:
                begin
                    // Taken from state at the moment of the read [RULE4] [RULE13]
                    rdata_next[7:0] = adjust_value;
                end
                default:
                begin
                    rresp_next = bcdcu_pkg::RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            acc_reg     <= bcdcu_pkg::ACC_RESET;
            carry_reg   <= 1'b0;
            half_reg    <= 1'b0;
            operand_reg <= 8'h00;
            awready_reg <= 1'b0;
            wready_reg  <= 1'b0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= bcdcu_pkg::RESP_OKAY;
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= 32'h0000_0000;
            rresp_reg   <= bcdcu_pkg::RESP_OKAY;
        end
        else
        begin
            acc_reg     <= acc_next;
            carry_reg   <= carry_next;
            half_reg    <= half_next;
            operand_reg <= operand_next;
            awready_reg <= awready_next;
            wready_reg  <= wready_next;
            bvalid_reg  <= bvalid_next;
            bresp_reg   <= bresp_next;
            arready_reg <= arready_next;
            rvalid_reg  <= rvalid_next;
            rdata_reg   <= rdata_next;
            rresp_reg   <= rresp_next;
        end
    end

    assign s_axi_awready = awready_reg;
    assign s_axi_wready  = wready_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    sequence s_low_fix;
        half_reg || (acc_reg[3:0] > 4'h9);
    endsequence

    a_low_digit_fix: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE15]
        s_low_fix |-> adjust_value[3:0] == 4'h6)
        else $error("low correction digit not six");
    a_high_digit_fix: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE15]
        (carry_reg || acc_reg > 8'h99) == (adjust_value[7:4] == 4'h6))
        else $error("high correction digit wrong");
    a_adjust_read: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE4]
        rd_fire && s_axi_araddr == 12'h0FC |=> rdata_reg[7:0] == $past(adjust_value)
        && rdata_reg[31:8] == 24'h000000)
        else $error("correction read does not match state");
    a_add_result: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE2]
        wr_fire && s_axi_awaddr == 12'h00C && s_axi_wstrb[0] && s_axi_wdata[1:0] == 2'h1
        |=> acc_reg == $past(acc_reg) + $past(operand_reg))
        else $error("binary sum not stored");
    a_sub_result: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE10]
        wr_fire && s_axi_awaddr == 12'h00C && s_axi_wstrb[0] && s_axi_wdata[1:0] == 2'h2
        |=> acc_reg == $past(acc_reg) - $past(operand_reg))
        else $error("binary difference not stored");
    a_sum_example: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE7]
        acc_reg == 8'h22 && carry_reg && half_reg |-> adjust_value == 8'h66)
        else $error("correction for 22H case wrong");
    a_zero_example: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE9]
        acc_reg == 8'h00 && carry_reg && !half_reg |-> adjust_value == 8'h60)
        else $error("correction for 00H case wrong");
    a_rollover_example: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE8]
        acc_reg == 8'h9A && !carry_reg && !half_reg |-> adjust_value == 8'h66)
        else $error("correction for 9AH case wrong");
    a_carry_kept: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE3] [RULE11]
        wr_fire && s_axi_awaddr == 12'h00C && s_axi_wstrb[0] && carry_reg
        && (s_axi_wdata[1:0] == 2'h3 || s_axi_wdata[1:0] == 2'h0) |=> carry_reg)
        else $error("correcting step lost the decimal carry");
    a_sub_example: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE12]
        acc_reg == 8'h3F && !carry_reg && half_reg |-> adjust_value == 8'h06)
        else $error("correction for 3FH case wrong");
    a_adj_readonly: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE13]
        wr_fire && s_axi_awaddr == 12'h0FC |=> bresp_reg == 2'h2 && acc_reg == $past(acc_reg))
        else $error("write to correction location accepted");
    a_write_answer: assert property (@(posedge clk_sys) disable iff (sys_rst)
        wr_fire |=> bvalid_reg && awready_reg && wready_reg ##1 !awready_reg)
        else $error("write answer timing wrong");
endmodule
`default_nettype wire

// ---- bench/bcdcu_seq_model.sv ----
// Sequencer model: AXI4-Lite master issuing accumulator operations one at a time
`default_nettype none
module bcdcu_seq_model
(
    // Clock
    input  wire logic        clk_sys,
    // Write side
    output logic [11:0]      awaddr,
    output logic             awvalid,
    input  wire logic        awready,
    output logic [31:0]      wdata,
    output logic [3:0]       wstrb,
    output logic             wvalid,
    input  wire logic        wready,
    input  wire logic [1:0]  bresp,
    input  wire logic        bvalid,
    output logic             bready,
    // Read side
    output logic [11:0]      araddr,
    output logic             arvalid,
    input  wire logic        arready,
    input  wire logic [31:0] rdata,
    input  wire logic [1:0]  rresp,
    input  wire logic        rvalid,
    output logic             rready
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Only one access in flight, so nothing can slip between two operations
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [1:0] resp);
        @(posedge clk_sys);
        awaddr  <= a;
        awvalid <= 1'b1;
        wdata   <= d;
        wstrb   <= s;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do
        begin
            @(posedge clk_sys);
            // Released lines show the inverse so stale data is never mistaken
            if (awready)
            begin
                awvalid <= 1'b0;
                awaddr  <= ~a;
            end
            if (wready)
            begin
                wvalid <= 1'b0;
                wdata  <= ~d;
            end
        end while (!bvalid);
        resp = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] resp);
        @(posedge clk_sys);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do
        begin
            @(posedge clk_sys);
            if (arready)
            begin
                arvalid <= 1'b0;
                araddr  <= ~a;
            end
        end while (!rvalid);
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- bench/tb_bcd_correction_unit.sv ----
// Testbench: accumulator decimal correction against an integer model
`default_nettype none
module tb_bcd_correction_unit;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys, sys_rst;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rv;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, rs;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    int          n_fail, check_count, m_acc, m_cy, m_hc, m_op, da, db, sb, f, i;
    int          ex[4][5] = '{'{'h99, 'h89, 0, 'h88, 1}, '{'h85, 'h15, 0, 'h00, 3},
                              '{'h80, 'h80, 0, 'h60, 1}, '{'h91, 'h52, 1, 'h39, 0}};

    bcdcu_top u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));
    bcdcu_seq_model u_seq (.clk_sys(clk_sys), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready));

    initial
    begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        if (n_fail == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Upper data bits are random: only the low byte may matter
    task automatic w(input logic [11:0] a, input int d);
        u_seq.wr(a, {24'($urandom()), 8'(d)}, 4'h1, rs);
        chk(32'(rs), 32'(bcdcu_pkg::RESP_OKAY));
    endtask

    task automatic r(input logic [11:0] a, input int e);
        u_seq.rd(a, rv, rs);
        chk(32'(rs), 32'(bcdcu_pkg::RESP_OKAY));
        chk(rv, 32'(e));
    endtask

    function automatic int adj(input int a, input int c, input int h);
        return ((c != 0 || a > 'h99) ? 'h60 : 0) + ((h != 0 || a % 16 > 9) ? 6 : 0);
    endfunction

    // Codes: 1 add operand, 2 subtract operand, 3 add correction, 0 subtract correction
    task automatic op(input int code);
        int b;
        int add;
        int res;
        b = (code == 1 || code == 2) ? m_op : adj(m_acc, m_cy, m_hc);
        add = (code == 1 || code == 3);
        res = add ? m_acc + b : m_acc - b;
        m_hc = add ? (m_acc % 16 + b % 16 > 15) : (m_acc % 16 < b % 16);
        // A decimal carry or borrow from either step survives the correction
        m_cy = (add ? res > 255 : m_acc < b) || ((code == 3 || code == 0) && m_cy != 0);
        m_acc = res & 255;
        w(bcdcu_pkg::ADDR_COMMAND, code);
        r(bcdcu_pkg::ADDR_ACC, m_acc);
        r(bcdcu_pkg::ADDR_FLAGS, m_cy + 2 * m_hc);
    endtask

    task automatic run(input int a, input int b, input int sub);
        m_acc = a;
        m_op = b;
        m_cy = 0;
        m_hc = 0;
        w(bcdcu_pkg::ADDR_ACC, a);
        w(bcdcu_pkg::ADDR_FLAGS, 0);
        w(bcdcu_pkg::ADDR_OPERAND, b);
        op(sub ? 2 : 1);
        r(bcdcu_pkg::ADDR_ADJUST, adj(m_acc, m_cy, m_hc));
        op(sub ? 0 : 3);
    endtask

    function automatic int bcd(input int x);
        return x / 10 * 16 + x % 10;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        n_fail = 0;
        check_count = 0;
        sys_rst = 1'b1;
        da = $urandom(88468);
        repeat (8) @(posedge clk_sys);
        sys_rst <= 1'b0;
        r(bcdcu_pkg::ADDR_ACC, 0);
        r(bcdcu_pkg::ADDR_FLAGS, 0);
        r(bcdcu_pkg::ADDR_OPERAND, 0);
        for (i = 0; i < 4; i++)
        begin
            run(ex[i][0], ex[i][1], ex[i][2]);
            r(bcdcu_pkg::ADDR_ACC, ex[i][3]);
            r(bcdcu_pkg::ADDR_FLAGS, ex[i][4]);
        end
        repeat (40)
        begin
            da = $urandom_range(99);
            db = $urandom_range(99);
            sb = $urandom_range(1);
            run(bcd(da), bcd(db), sb);
            f = sb ? (da - db + 100) % 100 : (da + db) % 100;
            r(bcdcu_pkg::ADDR_ACC, bcd(f));
            u_seq.rd(bcdcu_pkg::ADDR_FLAGS, rv, rs);
            chk(32'(rv[0]), 32'(sb ? da < db : da + db > 99));
        end
        // Status restore after an interrupt changes the correction at once
        repeat (24)
        begin
            da = $urandom_range(255);
            f = $urandom_range(3);
            w(bcdcu_pkg::ADDR_ACC, da);
            w(bcdcu_pkg::ADDR_FLAGS, f);
            r(bcdcu_pkg::ADDR_ADJUST, adj(da, f % 2, f / 2));
        end
        w(bcdcu_pkg::ADDR_ACC, 'h42);
        w(bcdcu_pkg::ADDR_FLAGS, 0);
        u_seq.wr(bcdcu_pkg::ADDR_ADJUST, 32'h0000_0011, 4'hF, rs);
        chk(32'(rs), 32'(bcdcu_pkg::RESP_SLVERR));
        u_seq.wr(bcdcu_pkg::ADDR_ACC, 32'h0000_0017, 4'h0, rs);
        chk(32'(rs), 32'(bcdcu_pkg::RESP_OKAY));
        r(bcdcu_pkg::ADDR_ACC, 'h42);
        r(bcdcu_pkg::ADDR_ADJUST, 0);
        r(bcdcu_pkg::ADDR_COMMAND, 0);
        u_seq.rd(12'h010, rv, rs);
        chk(32'(rs), 32'(bcdcu_pkg::RESP_SLVERR));
        chk(rv, 32'h0000_0000);
        conclude();
    end

    initial
    begin
        repeat (40000) @(posedge clk_sys);
        n_fail++;
        conclude();
    end
endmodule
`default_nettype wire
